// ### bench/cgpc_monitor.sv
// Purpose: port checks for the cgpc register block
// Assumes: one clock, async active-low reset
// Notes: partner levels hold two cycles or more
`timescale 1ns/10ps
module cgpc_monitor #(
    parameter int NUM_CMP = 2
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwm_period_tick,
    input wire logic [NUM_CMP-1:0] cmp_irq_req,
    input wire logic pwm_hiz,
    input wire logic [7:0] ref_code0,
    input wire logic [1:0] amp_gain
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    ready_next_a: assert property (s_wait |=> s_done)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("stray pready");
    err_timing_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    upper_zero_a: assert property (s_done ##0 !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    cfg_hold_a: assert property (!(psel && penable && pwrite && pready) |=>
        $stable({ref_code0, amp_gain})) else $error("config moved");
    reset_clear_a: assert property (!$past(rst_b) |-> !pwm_hiz && ref_code0 == 8'h00)
        else $error("not cleared");
    hiz_hold_a: assert property (pwm_hiz && !pwm_period_tick |=> pwm_hiz)
        else $error("hiz left off period");
    irq_pulse_a: assert property (cmp_irq_req[0] |=> !cmp_irq_req[0])
        else $error("irq held");
endmodule

// ### bench/cgpc_partner.sv
// Purpose: pwm timer and comparator result model
// Assumes: results follow level_cmd one edge later
// Notes: period shortened to keep runs brief
`timescale 1ns/10ps
module cgpc_partner #(
    parameter int PERIOD = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [1:0] level_cmd,
    output logic [1:0] cmp_result,
    output logic pwm_period_tick
);
    logic [7:0] cnt_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 8'h00;
            cmp_result <= 2'h0;
            pwm_period_tick <= 1'b0;
        end else begin
            cmp_result <= level_cmd;
            cnt_r <= (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
            pwm_period_tick <= (cnt_r == 8'(PERIOD - 1));
        end
    end
endmodule

// ### bench/cgpc_regs_tb.sv
// Purpose: self-checking bench for the cgpc register block
// Assumes: apb slave answers in the second access cycle
// Notes: outputs read at edges, before that edge lands
`timescale 1ns/10ps
module cgpc_regs_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [23:0] paddr = 24'h000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [1:0] lvl = 2'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tick, pwm_hiz, amp_enable, err;
    logic [1:0] res, hz_out, irq, run_en, in_sel, gen_en, sup_sel, amp_gain;
    logic [7:0] ref_code0, ref_code1, d, rd;
    int n_mismatch = 0;
    int n_tests = 0;
    int irq_cnt = 0;
    int k;
    integer seed = 32'h6c11;
    logic [21:0] regs [5] = '{cgpc_pkg::IDX_PERIPH_EN, cgpc_pkg::IDX_CUTOFF_MODE,
        cgpc_pkg::IDX_CUTOFF_STATUS, cgpc_pkg::IDX_HIZ_START, cgpc_pkg::IDX_AMP_CTRL};
    logic [1:0] lvs [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (rst_b && irq != 2'h0) irq_cnt <= irq_cnt + 1;
    cgpc_partner #(.PERIOD(16)) u_far (.core_clk(core_clk), .rst_b(rst_b),
        .level_cmd(lvl), .cmp_result(res), .pwm_period_tick(tick));
    cgpc_regs DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_result(res), .pwm_period_tick(tick),
        .cmp_hiz_ctrl_out(hz_out), .cmp_irq_req(irq), .pwm_hiz(pwm_hiz),
        .cmp_run_enable(run_en), .cmp_input_select(in_sel), .ref_gen_enable(gen_en),
        .ref_supply_select(sup_sel), .ref_code0(ref_code0), .ref_code1(ref_code1),
        .amp_enable(amp_enable), .amp_gain(amp_gain));
    task automatic stop_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [21:0] idx, input logic [7:0] wd);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        err = pslverr;
        if (pready !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [21:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rdc(input string nm, input logic [21:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(nm, exp, rd);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    // hiz timing is only known to within one pwm period
    task automatic till(input logic v);
        int n = 0;
        while (pwm_hiz !== v && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        chk("pwm_hiz", 8'(v), 8'(pwm_hiz));
    endtask
    initial begin
        cyc(2);
        rst_b <= 1'b1;
        cyc(1);
        foreach (regs[i]) rdc("reset", regs[i], 8'h00);
        wr(cgpc_pkg::IDX_REF_SEL0, 8'hA5);
        wr(cgpc_pkg::IDX_CUTOFF_MODE, 8'h02);
        rdc("code0 off", cgpc_pkg::IDX_REF_SEL0, 8'h00);
        rdc("mode off", cgpc_pkg::IDX_CUTOFF_MODE, 8'h00);
        wr(cgpc_pkg::IDX_PERIPH_EN, 8'hFF);
        rdc("periph", cgpc_pkg::IDX_PERIPH_EN, 8'h60);
        wr(cgpc_pkg::IDX_CUTOFF_STATUS, 8'hFF);
        chk("status wr err", 8'h01, 8'(err));
        apb(1'b0, 22'h000100, 8'h00);
        chk("unmapped err", 8'h01, 8'(err));
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            wr(cgpc_pkg::IDX_REF_CTRL, d & 8'h55);
            chk("supply sel", 8'({d[4], d[0]}), 8'(sup_sel));
            chk("input sel", 8'({d[6], d[2]}), 8'(in_sel));
            wr(cgpc_pkg::IDX_REF_SEL0, d);
            wr(cgpc_pkg::IDX_REF_SEL1, ~d);
            chk("code0", d, ref_code0);
            chk("code1 port", ~d, ref_code1);
            rdc("code1", cgpc_pkg::IDX_REF_SEL1, ~d);
            wr(cgpc_pkg::IDX_AMP_CTRL, {1'b0, d[6:2], 2'(i)});
            wr(cgpc_pkg::IDX_AMP_CTRL, {1'b1, d[6:2], 2'(i)});
            rdc("amp", cgpc_pkg::IDX_AMP_CTRL, {6'h20, 2'(i)});
            chk("amp port", {6'h20, 2'(i)}, {amp_enable, 5'h00, amp_gain});
            wr(cgpc_pkg::IDX_CUTOFF_MODE, d);
            rdc("mode", cgpc_pkg::IDX_CUTOFF_MODE, d & 8'h02);
            wr(cgpc_pkg::IDX_AMP_CTRL, {6'h00, 2'(i)});
        end
        wr(cgpc_pkg::IDX_CUTOFF_MODE, 8'h00);
        wr(cgpc_pkg::IDX_HIZ_START, 8'hFE);
        cyc(4);
        chk("hiz on zero", 8'h00, 8'(pwm_hiz));
        wr(cgpc_pkg::IDX_REF_CTRL, 8'h22);
        chk("ref gen", 8'h03, 8'(gen_en));
        wr(cgpc_pkg::IDX_CMP_RUN, 8'h11);
        chk("run", 8'h03, 8'(run_en));
        wr(cgpc_pkg::IDX_CMP_OUT_CTRL, 8'h00);
        lvl <= 2'h3;
        cyc(6);
        chk("ctrl off", 8'h00, 8'(hz_out));
        lvl <= 2'h0;
        wr(cgpc_pkg::IDX_CMP_OUT_CTRL, 8'h22);
        k = irq_cnt;
        lvl <= 2'h1;
        cyc(6);
        chk("irq masked", 8'(k), 8'(irq_cnt));
        k = irq_cnt;
        wr(cgpc_pkg::IDX_CMP_OUT_CTRL, 8'h33);
        cyc(6);
        chk("irq on enable", 8'(k + 1), 8'(irq_cnt));
        k = irq_cnt;
        lvl <= 2'h0;
        cyc(6);
        chk("irq", 8'(k + 1), 8'(irq_cnt));
        wr(cgpc_pkg::IDX_CMP_OUT_CTRL, 8'h00);
        wr(cgpc_pkg::IDX_CMP_OUT_CTRL, 8'h22);
        lvl <= 2'h1;
        cyc(6);
        chk("ctrl on", 8'h01, 8'(hz_out));
        rdc("levels", cgpc_pkg::IDX_CUTOFF_STATUS, 8'h01);
        wr(cgpc_pkg::IDX_CMP_OUT_CTRL, 8'h66);
        cyc(6);
        chk("polarity", 8'h02, 8'(hz_out));
        wr(cgpc_pkg::IDX_CMP_OUT_CTRL, 8'h22);
        lvl <= 2'h0;
        wr(cgpc_pkg::IDX_HIZ_START, 8'h01);
        till(1'b1);
        rdc("hiz flag", cgpc_pkg::IDX_CUTOFF_STATUS, 8'h04);
        rdc("start rd", cgpc_pkg::IDX_HIZ_START, 8'h00);
        wr(cgpc_pkg::IDX_CUTOFF_MODE, 8'h02);
        wr(cgpc_pkg::IDX_HIZ_CANCEL, 8'h01);
        cyc(40);
        chk("cancel mode1", 8'h01, 8'(pwm_hiz));
        for (int m = 0; m < 4; m++) begin
            wr(cgpc_pkg::IDX_CUTOFF_MODE, 8'h00);
            wr(cgpc_pkg::IDX_HIZ_CANCEL, 8'h01);
            till(1'b0);
            wr(cgpc_pkg::IDX_CUTOFF_MODE, {6'h00, m[1], 1'b0});
            lvl <= lvs[m];
            cyc(20);
            chk("trip", 8'(m != 0), 8'(pwm_hiz));
            if (m == 1) begin
                wr(cgpc_pkg::IDX_HIZ_CANCEL, 8'h01);
                cyc(40);
                chk("cancel high", 8'h01, 8'(pwm_hiz));
            end
            lvl <= 2'h0;
            cyc(6);
        end
        // second reset in mid-run, with hiz and codes still set
        rst_b <= 1'b0;
        cyc(2);
        chk("rst hiz", 8'h00, 8'(pwm_hiz));
        chk("rst code1", 8'h00, ref_code1);
        rst_b <= 1'b1;
        cyc(1);
        foreach (regs[i]) rdc("reset again", regs[i], 8'h00);
        stop_test();
    end
endmodule
bind cgpc_regs cgpc_monitor #(.NUM_CMP(NUM_CMP)) u_mon (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_period_tick(pwm_period_tick), .cmp_irq_req(cmp_irq_req),
    .pwm_hiz(pwm_hiz), .ref_code0(ref_code0), .amp_gain(amp_gain));

// ### core/cgpc_regs.sv
// Purpose: register bank for two comparators, gain amplifier and pwm cutoff
// Assumes: apb3 master, comparator results synchronous to core_clk
// Notes: pready comes one cycle after the first access cycle
`timescale 1ns/10ps
module cgpc_regs #(
    parameter int NUM_CMP = 2
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cgpc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CMP-1:0] cmp_result,
    input wire logic pwm_period_tick,
    output logic [NUM_CMP-1:0] cmp_hiz_ctrl_out,
    output logic [NUM_CMP-1:0] cmp_irq_req,
    output logic pwm_hiz,
    output logic [NUM_CMP-1:0] cmp_run_enable,
    output logic [NUM_CMP-1:0] cmp_input_select,
    output logic [NUM_CMP-1:0] ref_gen_enable,
    output logic [NUM_CMP-1:0] ref_supply_select,
    output logic [7:0] ref_code0,
    output logic [7:0] ref_code1,
    output logic amp_enable,
    output logic [1:0] amp_gain
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] periph_en;
        logic [7:0] cutoff_mode;
        logic [7:0] cmp_run;
        logic [7:0] cmp_out_ctrl;
        logic [7:0] ref_ctrl;
        logic [7:0] ref_sel0;
        logic [7:0] ref_sel1;
        logic [7:0] amp_ctrl;
        logic start_trig;
        logic cancel_pend;
        logic hiz;
        logic [NUM_CMP-1:0] level;
        logic [NUM_CMP-1:0] prev_level;
        logic [NUM_CMP-1:0] prev_irq_en;
        logic [NUM_CMP-1:0] irq;
    } cgpc_state_t;

    cgpc_state_t st_r;
    cgpc_state_t st_nxt;

    // register index decode, also used for the error answer
    function automatic logic mapped(input logic [21:0] idx);
        mapped = idx inside {cgpc_pkg::IDX_PERIPH_EN, cgpc_pkg::IDX_CUTOFF_MODE,
            cgpc_pkg::IDX_CUTOFF_STATUS, cgpc_pkg::IDX_HIZ_START,
            cgpc_pkg::IDX_HIZ_CANCEL, cgpc_pkg::IDX_CMP_RUN,
            cgpc_pkg::IDX_CMP_OUT_CTRL, cgpc_pkg::IDX_REF_CTRL,
            cgpc_pkg::IDX_REF_SEL0, cgpc_pkg::IDX_REF_SEL1, cgpc_pkg::IDX_AMP_CTRL};
    endfunction

    // bit position of a per comparator field
    function automatic int cmp_bit(input int base, input int i);
        cmp_bit = base + i * cgpc_pkg::CMP_STRIDE;
    endfunction

    logic [21:0] idx;
    logic word_ok;
    logic analog_on;
    logic cutoff_on;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [7:0] status;
    logic [NUM_CMP-1:0] raw_level;
    logic wr_now;

    assign idx = paddr[cgpc_pkg::ADDR_W-1:2];
    assign word_ok = (paddr[1:0] == 2'h0) && mapped(idx);
    assign analog_on = st_r.periph_en[cgpc_pkg::BIT_ANALOG_CLK_EN];
    assign cutoff_on = st_r.periph_en[cgpc_pkg::BIT_CUTOFF_CLK_EN];
    assign wbyte = pwdata[7:0];
    assign wr_now = psel && penable && st_r.pready && pwrite && word_ok && !st_r.pslverr;
    assign status = {5'h00, st_r.hiz, st_r.level[1], st_r.level[0]};

    // comparator output signal: result through polarity, gated by output enable
    generate
        for (genvar i = 0; i < NUM_CMP; i++) begin : g_lvl
            assign raw_level[i] = st_r.cmp_out_ctrl[cmp_bit(cgpc_pkg::BIT_CMP_OUT_EN, i)]
                && (cmp_result[i]
                ^ st_r.cmp_out_ctrl[cmp_bit(cgpc_pkg::BIT_CMP_OUT_POL, i)]);
        end
    endgenerate

    always_comb begin
        rbyte = 8'h00;
        case (idx)
            cgpc_pkg::IDX_PERIPH_EN: rbyte = st_r.periph_en;
            cgpc_pkg::IDX_CUTOFF_MODE:
                rbyte = cutoff_on ? st_r.cutoff_mode : cgpc_pkg::RESET_VAL;
            cgpc_pkg::IDX_CUTOFF_STATUS: rbyte = cutoff_on ? status : cgpc_pkg::RESET_VAL;
            cgpc_pkg::IDX_HIZ_START: rbyte = 8'h00;
            cgpc_pkg::IDX_HIZ_CANCEL: rbyte = 8'h00;
            cgpc_pkg::IDX_CMP_RUN: rbyte = st_r.cmp_run;
            cgpc_pkg::IDX_CMP_OUT_CTRL: rbyte = st_r.cmp_out_ctrl;
            cgpc_pkg::IDX_REF_CTRL: rbyte = st_r.ref_ctrl;
            cgpc_pkg::IDX_REF_SEL0: rbyte = st_r.ref_sel0;
            cgpc_pkg::IDX_REF_SEL1: rbyte = st_r.ref_sel1;
            cgpc_pkg::IDX_AMP_CTRL: rbyte = st_r.amp_ctrl;
            default: rbyte = 8'h00;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.irq = '0;
        // apb: answer one cycle after the first access cycle
        if (psel && penable && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !word_ok || (pwrite && idx == cgpc_pkg::IDX_CUTOFF_STATUS);
            st_nxt.prdata = (pwrite || !word_ok) ? 32'h0000_0000 : {24'h000000, rbyte};
        end else begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
        if (wr_now) begin
            case (idx)
                cgpc_pkg::IDX_PERIPH_EN:
                    st_nxt.periph_en = wbyte & cgpc_pkg::MASK_PERIPH_EN;
                cgpc_pkg::IDX_CUTOFF_MODE: begin
                    if (cutoff_on) begin
                        st_nxt.cutoff_mode = wbyte & cgpc_pkg::MASK_CUTOFF_MODE;
                    end
                end
                cgpc_pkg::IDX_HIZ_START: begin
                    if (cutoff_on && wbyte[cgpc_pkg::BIT_HIZ_TRIGGER]) begin
                        st_nxt.start_trig = 1'b1;
                    end
                end
                cgpc_pkg::IDX_HIZ_CANCEL: begin
                    if (cutoff_on && wbyte[cgpc_pkg::BIT_HIZ_TRIGGER]
                        && !st_r.cutoff_mode[cgpc_pkg::BIT_CUTOFF_MODE]
                        && st_r.level == '0 && st_r.hiz) begin
                        st_nxt.cancel_pend = 1'b1;
                    end
                end
                cgpc_pkg::IDX_CMP_RUN: begin
                    if (analog_on) begin
                        st_nxt.cmp_run = wbyte & cgpc_pkg::MASK_CMP_RUN;
                    end
                end
                cgpc_pkg::IDX_CMP_OUT_CTRL: begin
                    if (analog_on) begin
                        st_nxt.cmp_out_ctrl = wbyte & cgpc_pkg::MASK_CMP_OUT_CTRL;
                    end
                end
                cgpc_pkg::IDX_REF_CTRL: begin
                    if (analog_on) begin
                        st_nxt.ref_ctrl = wbyte & cgpc_pkg::MASK_REF_CTRL;
                    end
                end
                cgpc_pkg::IDX_REF_SEL0: begin
                    if (analog_on) begin
                        st_nxt.ref_sel0 = wbyte;
                    end
                end
                cgpc_pkg::IDX_REF_SEL1: begin
                    if (analog_on) begin
                        st_nxt.ref_sel1 = wbyte;
                    end
                end
                cgpc_pkg::IDX_AMP_CTRL: begin
                    if (analog_on) begin
                        st_nxt.amp_ctrl = wbyte & cgpc_pkg::MASK_AMP_CTRL;
                    end
                end
                default: begin
                end
            endcase
        end
        // comparator levels and interrupt requests
        st_nxt.level = raw_level;
        st_nxt.prev_level = st_r.level;
        for (int i = 0; i < NUM_CMP; i++) begin
            st_nxt.prev_irq_en[i] = st_r.cmp_out_ctrl[cmp_bit(cgpc_pkg::BIT_CMP_IRQ_EN, i)];
            if (st_nxt.prev_irq_en[i]) begin
                // enable rise with level high reads as an edge, the request clears itself after one cycle
                st_nxt.irq[i] = (st_r.level[i] != st_r.prev_level[i])
                    || (!st_r.prev_irq_en[i] && st_r.level[i]);
            end
        end
        // hiz control: one flag drives pwm_hiz and the status hiz bit together
        if (st_r.hiz) begin
            // retire only a trigger already seen; a fresh write survives a cancel
            if (st_r.start_trig) begin
                st_nxt.start_trig = 1'b0;
            end
            if (st_r.cancel_pend && pwm_period_tick) begin
                st_nxt.hiz = 1'b0;
                st_nxt.cancel_pend = 1'b0;
            end
        end else begin
            st_nxt.cancel_pend = 1'b0;
            if (st_r.start_trig) begin
                st_nxt.hiz = 1'b1;
            end else if (st_r.cutoff_mode[cgpc_pkg::BIT_CUTOFF_MODE]) begin
                // induced current mode: either comparator forces cutoff
                st_nxt.hiz = |st_r.level;
            end else begin
                // two-stage mode: hard stop only when both stages trip
                st_nxt.hiz = &st_r.level;
            end
        end
        // a stopped clock holds the unit in reset; its registers fall back to zero
        if (!analog_on) begin
            st_nxt.cmp_run = cgpc_pkg::RESET_VAL;
            st_nxt.cmp_out_ctrl = cgpc_pkg::RESET_VAL;
            st_nxt.ref_ctrl = cgpc_pkg::RESET_VAL;
            st_nxt.ref_sel0 = cgpc_pkg::RESET_VAL;
            st_nxt.ref_sel1 = cgpc_pkg::RESET_VAL;
            st_nxt.amp_ctrl = cgpc_pkg::RESET_VAL;
            st_nxt.irq = '0;
        end
        if (!cutoff_on) begin
            st_nxt.cutoff_mode = cgpc_pkg::RESET_VAL;
            st_nxt.start_trig = 1'b0;
            st_nxt.cancel_pend = 1'b0;
            st_nxt.hiz = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign cmp_hiz_ctrl_out = st_r.level;
    assign cmp_irq_req = st_r.irq;
    assign pwm_hiz = st_r.hiz;
    assign amp_enable = st_r.amp_ctrl[cgpc_pkg::BIT_AMP_EN];
    assign amp_gain = st_r.amp_ctrl[1:0];
    assign ref_code0 = st_r.ref_sel0;
    assign ref_code1 = st_r.ref_sel1;
    generate
        for (genvar i = 0; i < NUM_CMP; i++) begin : g_out
            assign cmp_run_enable[i] = st_r.cmp_run[cmp_bit(cgpc_pkg::BIT_CMP_RUN, i)];
            assign cmp_input_select[i] = st_r.ref_ctrl[cmp_bit(cgpc_pkg::BIT_CMP_IN_SEL, i)];
            assign ref_gen_enable[i] = st_r.ref_ctrl[cmp_bit(cgpc_pkg::BIT_REF_GEN_EN, i)];
            assign ref_supply_select[i] = st_r.ref_ctrl[cmp_bit(cgpc_pkg::BIT_REF_SUPPLY, i)];
        end
    endgenerate
endmodule

// ### shared/cgpc_pkg.sv
// Purpose: constants for the comparator, gain amplifier and pwm cutoff registers
// Assumes: apb byte address is four times the register index
// Notes: all registers are 8 bits wide in the low byte of the word
package cgpc_pkg;
    localparam int ADDR_W = 24;
    localparam logic [21:0] IDX_PERIPH_EN = 22'h0F007A;
    localparam logic [21:0] IDX_CUTOFF_MODE = 22'h0F026C;
    localparam logic [21:0] IDX_CUTOFF_STATUS = 22'h0F026D;
    localparam logic [21:0] IDX_HIZ_START = 22'h0F026E;
    localparam logic [21:0] IDX_HIZ_CANCEL = 22'h0F026F;
    localparam logic [21:0] IDX_CMP_RUN = 22'h0F0340;
    localparam logic [21:0] IDX_CMP_OUT_CTRL = 22'h0F0342;
    localparam logic [21:0] IDX_REF_CTRL = 22'h0F0343;
    localparam logic [21:0] IDX_REF_SEL0 = 22'h0F0344;
    localparam logic [21:0] IDX_REF_SEL1 = 22'h0F0345;
    localparam logic [21:0] IDX_AMP_CTRL = 22'h0F0346;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // writable bit masks; other bits are fixed zero
    localparam logic [7:0] MASK_PERIPH_EN = 8'h60;
    localparam logic [7:0] MASK_CUTOFF_MODE = 8'h02;
    localparam logic [7:0] MASK_CMP_RUN = 8'h11;
    localparam logic [7:0] MASK_CMP_OUT_CTRL = 8'h77;
    localparam logic [7:0] MASK_REF_CTRL = 8'h77;
    localparam logic [7:0] MASK_AMP_CTRL = 8'h83;
    localparam int BIT_ANALOG_CLK_EN = 5;
    localparam int BIT_CUTOFF_CLK_EN = 6;
    localparam int BIT_CUTOFF_MODE = 1;
    localparam int BIT_HIZ_STATE = 2;
    localparam int BIT_HIZ_TRIGGER = 0;
    localparam int BIT_AMP_EN = 7;
    // per comparator field base: comparator i at base + 4*i
    localparam int BIT_CMP_IRQ_EN = 0;
    localparam int BIT_CMP_OUT_EN = 1;
    localparam int BIT_CMP_OUT_POL = 2;
    localparam int BIT_REF_SUPPLY = 0;
    localparam int BIT_REF_GEN_EN = 1;
    localparam int BIT_CMP_IN_SEL = 2;
    localparam int BIT_CMP_RUN = 0;
    localparam int CMP_STRIDE = 4;
endpackage
